// [hw/gpev_pkg.sv]
package gpev_pkg;

  localparam int unsigned NUM_PINS     = 19;
  localparam int unsigned LANE_W       = 8;
  localparam int unsigned MUX_W        = 3;
  localparam int unsigned IDX_W        = 5;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned OTHER_EV_BIT = 19;

  // Byte addresses of the register words
  localparam logic [7:0] DIR_OFF       = 8'h00;
  localparam logic [7:0] OUT_ON_OFF    = 8'h04;
  localparam logic [7:0] OUT_OFF_OFF   = 8'h08;
  localparam logic [7:0] INPUT_OFF     = 8'h0C;
  localparam logic [7:0] LANE_SEL_OFF  = 8'h10;
  localparam logic [7:0] LANE_DATA_OFF = 8'h14;
  localparam logic [7:0] EV_EN_SET_OFF = 8'h18;
  localparam logic [7:0] EV_EN_CLR_OFF = 8'h1C;
  localparam logic [7:0] EV_RISE_OFF   = 8'h20;
  localparam logic [7:0] EV_FALL_OFF   = 8'h24;
  localparam logic [7:0] EV_STAT_OFF   = 8'h28;
  localparam logic [7:0] MUX_IDX_OFF   = 8'h2C;
  localparam logic [7:0] MUX_VAL_OFF   = 8'h30;
  localparam logic [7:0] WK_EN_SET_OFF = 8'h40;
  localparam logic [7:0] WK_EN_CLR_OFF = 8'h44;
  localparam logic [7:0] WK_RISE_OFF   = 8'h48;
  localparam logic [7:0] WK_FALL_OFF   = 8'h4C;
  localparam logic [7:0] WK_STAT_OFF   = 8'h50;

  // Reset values
  localparam logic [NUM_PINS-1:0] DIR_RST    = '0;
  localparam logic [NUM_PINS-1:0] OUT_RST    = '0;
  localparam logic [NUM_PINS-1:0] EV_EN_RST  = '0;
  localparam logic [NUM_PINS-1:0] EV_RISE_RST = '1;
  localparam logic [MUX_W-1:0]    MUX_RST    = 3'h0;

  // Selector index limits
  localparam logic [IDX_W-1:0] IDX_LAST_LOW = 5'h0F;
  localparam logic [IDX_W-1:0] IDX_HI_A     = 5'h11;
  localparam logic [IDX_W-1:0] IDX_HI_B     = 5'h12;
  localparam logic [DATA_W-1:0] BAD_IDX_WORD = 32'hFFFFFFFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] enable;
  } gpev_drive_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] own;
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] enable;
  } gpev_periph_t;

endpackage

// [hw/gpev_top.sv]
`timescale 1ns/10ps
// Overview of operation
// R1: Selector readback is four bits; bits 0-2 hold function, bit 3 reads zero.
// R2: Selector readback valid only for pin indices 0-15, 17 and 18.
// R3: Out-of-range selector index reads back as an all-ones word.
// R4: Input word shows every pin level in any mode; unused bits zero.
// R5: Lane byte write drives pins 0-7 or 8-15, LSB on lowest pin.
// R6: Software sets all lane pins to output before a lane byte write.
// R7: Lane byte read returns selected eight pin levels, lowest pin in LSB.
// R8: Event enables use set and clear maps over bits 0-18; reset disabled.
// R9: Pins zero in both maps keep their enable or edge setting.
// R10: Pin in both enable and disable maps ends up disabled.
// R11: Edge chosen per pin by rising and falling maps; reset and tie rising.
// R12: Event settings act only on pins configured as inputs.
// R13: Event settings still act on pins owned by another peripheral.
// R14: Event enable and edge settings survive sleep unchanged.
// R15: Wake view and event view share the same enable and edge bits.
// R16: Configured edge latches status even with event signalling disabled.
// R17: Status read returns pin and other port events and clears them.
// R18: Status valid for any direction, ownership and after sleep; unused bits zero.
// R19: Enabled pin events raise the system controller request line.
// R20: Direction map bit set makes pin an output, clear an input.
// R21: Output on and off maps update levels; both set drives low.
// R22: Pins pass a two-stage synchroniser; edges compare consecutive samples.
module gpev_top
  import gpev_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // AXI4-Lite write address
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // AXI4-Lite write response
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  // AXI4-Lite read data
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // General pins
  input  wire logic [NUM_PINS-1:0]  general_pin_in,
  output gpev_drive_t               general_pin_drive,
  // Other on-chip peripherals
  input  wire gpev_periph_t         periph_pins,
  output logic [NUM_PINS-1:0]       periph_pin_in,
  input  wire logic                 other_port_event,
  // System controller
  output logic                      sysctrl_event_req
);

  logic                  rst_meta_reg;
  logic                  rst_n_reg;
  logic [NUM_PINS-1:0]   sync1_reg;
  logic [NUM_PINS-1:0]   sync2_reg;
  logic [NUM_PINS-1:0]   prev_reg;
  logic [2:0]            hist_ok_reg;
  logic [NUM_PINS-1:0]   dir_reg;
  logic [NUM_PINS-1:0]   out_reg;
  logic [NUM_PINS-1:0]   out_next;
  logic [NUM_PINS-1:0]   ev_en_reg;
  logic [NUM_PINS-1:0]   ev_en_next;
  logic [NUM_PINS-1:0]   rise_reg;
  logic [NUM_PINS-1:0]   rise_next;
  logic [NUM_PINS:0]     status_reg;
  logic [NUM_PINS:0]     status_next;
  logic [NUM_PINS:0]     new_ev;
  logic [NUM_PINS-1:0]   pin_hit;
  logic [MUX_W-1:0]      mux_reg [NUM_PINS];
  logic [IDX_W-1:0]      mux_idx_reg;
  logic                  lane_sel_reg;
  logic                  aw_held_reg;
  logic [ADDR_W-1:0]     aw_addr_reg;
  logic                  w_held_reg;
  logic [DATA_W-1:0]     w_data_reg;
  logic [3:0]            w_strb_reg;
  logic                  wr_fire;
  logic [DATA_W-1:0]     wd;
  logic [DATA_W-1:0]     wmask;
  logic [DATA_W-1:0]     rd_word;
  logic                  rd_ok;
  logic                  rd_fire;
  logic                  stat_clr;

  function automatic logic idx_ok(input logic [IDX_W-1:0] idx); // R2
    return (idx <= IDX_LAST_LOW) || (idx == IDX_HI_A) || (idx == IDX_HI_B);
  endfunction

  function automatic logic [DATA_W-1:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Set/clear map update; clear wins on a tie
  function automatic logic [NUM_PINS-1:0] set_clr(input logic [NUM_PINS-1:0] cur,
                                                  input logic [NUM_PINS-1:0] set_m,
                                                  input logic [NUM_PINS-1:0] clr_m);
    return (cur | set_m) & ~clr_m; // R9 R10 R21
  endfunction

  // Reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Pin synchroniser and edge history
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sync1_reg   <= '0;
      sync2_reg   <= '0;
      prev_reg    <= '0;
      hist_ok_reg <= '0;
    end else begin
      sync1_reg   <= general_pin_in; // R22
      sync2_reg   <= sync1_reg;      // R22
      prev_reg    <= sync2_reg;      // R22
      hist_ok_reg <= {hist_ok_reg[1:0], 1'b1};
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wmask         = strb_mask(w_strb_reg);
  assign wd            = w_data_reg & wmask;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= '0;
      w_held_reg   <= 1'b0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_reg)
          DIR_OFF, OUT_ON_OFF, OUT_OFF_OFF, LANE_SEL_OFF, LANE_DATA_OFF,
          EV_EN_SET_OFF, EV_EN_CLR_OFF, EV_RISE_OFF, EV_FALL_OFF,
          WK_EN_SET_OFF, WK_EN_CLR_OFF, WK_RISE_OFF, WK_FALL_OFF,
          MUX_IDX_OFF, MUX_VAL_OFF: s_axi_bresp <= RESP_OKAY;
          default:                  s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Direction, lane select and selector index
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dir_reg      <= DIR_RST;
      lane_sel_reg <= 1'b0;
      mux_idx_reg  <= '0;
    end else if (wr_fire) begin
      if (aw_addr_reg == DIR_OFF) begin
        dir_reg <= (dir_reg & ~wmask[NUM_PINS-1:0]) | wd[NUM_PINS-1:0]; // R20
      end
      if (aw_addr_reg == LANE_SEL_OFF && w_strb_reg[0]) begin
        lane_sel_reg <= wd[0];
      end
      if (aw_addr_reg == MUX_IDX_OFF && w_strb_reg[0]) begin
        mux_idx_reg <= wd[IDX_W-1:0];
      end
    end
  end

  // Output levels
  always_comb begin
    out_next = out_reg;
    if (wr_fire) begin
      unique case (aw_addr_reg)
        OUT_ON_OFF:  out_next = set_clr(out_reg, wd[NUM_PINS-1:0], '0); // R21
        OUT_OFF_OFF: out_next = set_clr(out_reg, '0, wd[NUM_PINS-1:0]); // R21
        LANE_DATA_OFF: begin
          if (lane_sel_reg) begin
            out_next[2*LANE_W-1:LANE_W] = wd[LANE_W-1:0]; // R5
          end else begin
            out_next[LANE_W-1:0] = wd[LANE_W-1:0]; // R5
          end
        end
        default: out_next = out_reg;
      endcase
    end
  end

  // A lone off-write cannot see a pending on-write; both maps in one update are
  // only possible through separate words, so the later write decides.
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      out_reg <= OUT_RST;
    end else begin
      out_reg <= out_next;
    end
  end

  // Per-pin function selector
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        mux_reg[i] <= MUX_RST;
      end
    end else if (wr_fire && aw_addr_reg == MUX_VAL_OFF && w_strb_reg[0]
                 && idx_ok(mux_idx_reg)) begin
      mux_reg[mux_idx_reg] <= wd[MUX_W-1:0];
    end
  end

  // Shared event and wake settings
  always_comb begin
    ev_en_next = ev_en_reg;
    rise_next  = rise_reg;
    if (wr_fire) begin
      unique case (aw_addr_reg)
        EV_EN_SET_OFF, WK_EN_SET_OFF:
          ev_en_next = set_clr(ev_en_reg, wd[NUM_PINS-1:0], '0); // R8 R15
        EV_EN_CLR_OFF, WK_EN_CLR_OFF:
          ev_en_next = set_clr(ev_en_reg, '0, wd[NUM_PINS-1:0]); // R8 R15
        EV_RISE_OFF, WK_RISE_OFF:
          rise_next = rise_reg | wd[NUM_PINS-1:0];  // R11 R15
        EV_FALL_OFF, WK_FALL_OFF:
          rise_next = rise_reg & ~wd[NUM_PINS-1:0]; // R11 R15
        default: begin
          ev_en_next = ev_en_reg;
          rise_next  = rise_reg;
        end
      endcase
    end
  end

  // Cleared only by the power-on reset, never by a sleep cycle
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ev_en_reg <= EV_EN_RST;   // R8
      rise_reg  <= EV_RISE_RST; // R11
    end else begin
      ev_en_reg <= ev_en_next;  // R14
      rise_reg  <= rise_next;   // R14
    end
  end

  // Edge detection; output pins keep the default rising edge
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (rise_reg[i] || dir_reg[i]) begin // R11 R12
        pin_hit[i] = sync2_reg[i] && !prev_reg[i]; // R22
      end else begin
        pin_hit[i] = !sync2_reg[i] && prev_reg[i]; // R22
      end
    end
    // No edges until the history holds real samples: a pin high through reset shows none
    new_ev = {other_port_event, pin_hit & {NUM_PINS{hist_ok_reg[2]}}}; // R16 R13 R18
  end

  // AXI4-Lite read side, one cycle to rvalid
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign stat_clr      = rd_fire && (s_axi_araddr == EV_STAT_OFF || s_axi_araddr == WK_STAT_OFF);

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      DIR_OFF:                     rd_word[NUM_PINS-1:0] = dir_reg;
      OUT_ON_OFF, OUT_OFF_OFF:     rd_word[NUM_PINS-1:0] = out_reg;
      INPUT_OFF:                   rd_word[NUM_PINS-1:0] = sync2_reg; // R4
      LANE_SEL_OFF:                rd_word[0] = lane_sel_reg;
      LANE_DATA_OFF:               rd_word[LANE_W-1:0] = lane_sel_reg ?
                                     sync2_reg[2*LANE_W-1:LANE_W] : sync2_reg[LANE_W-1:0]; // R7
      EV_EN_SET_OFF, EV_EN_CLR_OFF,
      WK_EN_SET_OFF, WK_EN_CLR_OFF: rd_word[NUM_PINS-1:0] = ev_en_reg; // R15
      EV_RISE_OFF, WK_RISE_OFF:    rd_word[NUM_PINS-1:0] = rise_reg;
      EV_FALL_OFF, WK_FALL_OFF:    rd_word[NUM_PINS-1:0] = ~rise_reg;
      EV_STAT_OFF, WK_STAT_OFF:    rd_word[NUM_PINS:0] = status_reg; // R17 R18
      MUX_IDX_OFF:                 rd_word[IDX_W-1:0] = mux_idx_reg;
      MUX_VAL_OFF: begin
        if (idx_ok(mux_idx_reg)) begin
          rd_word[MUX_W-1:0] = mux_reg[mux_idx_reg]; // R1
        end else begin
          rd_word = BAD_IDX_WORD; // R3
        end
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Status: only reported bits are cleared, and a new event wins over the clear
  always_comb begin
    status_next = status_reg;
    if (stat_clr) begin
      status_next = '0; // R17
    end
    status_next = status_next | new_ev; // R16
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Request to the system controller, gated by input-only enables
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sysctrl_event_req <= 1'b0;
    end else begin
      sysctrl_event_req <= |(status_next[NUM_PINS-1:0] & ev_en_next & ~dir_reg); // R19 R12 R13
    end
  end

  // Pin drive; a peripheral that owns a pin overrides the port
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      general_pin_drive <= '0;
    end else begin
      general_pin_drive.level  <= (periph_pins.own & periph_pins.level)
                                  | (~periph_pins.own & out_next);
      general_pin_drive.enable <= (periph_pins.own & periph_pins.enable)
                                  | (~periph_pins.own & dir_reg);
    end
  end

  assign periph_pin_in = sync2_reg;

endmodule // gpev_top

// [testbench/gpev_chk.sv]
`timescale 1ns/10ps
module gpev_chk
  import gpev_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                nrst,
  // Write channels
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [1:0]          s_axi_bresp,
  // Read channels
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [ADDR_W-1:0]   s_axi_araddr,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [DATA_W-1:0]   s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  // Pins
  input wire logic [NUM_PINS-1:0] general_pin_in,
  input wire logic [NUM_PINS-1:0] periph_pin_in,
  input wire logic                sysctrl_event_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_r_after: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_w_to_b: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h38
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
  a_input_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == INPUT_OFF
    |=> s_axi_rdata[31:19] == 13'h0) else $error("unused input bits set");
  a_pin_sync: assert property ($past(nrst, 4) |-> periph_pin_in == $past(general_pin_in, 2))
    else $error("pin synchroniser depth wrong");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_req: cover property ($rose(sysctrl_event_req));
endmodule // gpev_chk

bind gpev_top gpev_chk u_chk (.*);

// [testbench/gpev_pins.sv]
`timescale 1ns/10ps
module gpev_pins
  import gpev_pkg::*;
(
  // Device side
  input  wire gpev_drive_t         drive,
  // External circuit levels
  input  wire logic [NUM_PINS-1:0] ext,
  // Resolved pin levels
  output logic [NUM_PINS-1:0]      pin
);
  // Undriven pins follow the external circuit, never a stale device value
  assign pin = (drive.level & drive.enable) | (ext & ~drive.enable);
endmodule // gpev_pins

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
  import gpev_pkg::*;
  typedef struct {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] ex;
  } gpev_row_t;
  logic                clk = 1'b0;
  logic                nrst;
  logic                s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [2:0]          s_axi_awprot, s_axi_arprot;
  logic [DATA_W-1:0]   s_axi_wdata, s_axi_rdata;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp, last_rsp;
  logic [NUM_PINS-1:0] general_pin_in, periph_pin_in, ext_lvl;
  gpev_drive_t         general_pin_drive;
  gpev_periph_t        periph_pins;
  logic                other_port_event, sysctrl_event_req;
  logic [31:0]         scratch;
  int                  fails = 0;
  int                  samples_checked = 0;
  gpev_row_t           rows [13];

  always #20 clk = ~clk;

  gpev_top dut (.*);
  gpev_pins u_pins (.drive(general_pin_drive), .ext(ext_lvl), .pin(general_pin_in));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int   n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge clk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      last_rsp = s_axi_bresp;
      n++;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hb);
    chk("write cycles", n, 3);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ha, hr;
    int   n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge clk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      last_rsp = s_axi_rresp;
      n++;
      @(posedge clk);
      if (ha) s_axi_arvalid <= 1'b0;
    end while (!hr);
    chk("read cycles", n, 2);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, ex);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    fails++;
    conclude();
  end

  initial begin
    rows = '{
      '{DIR_OFF, 32'h000FF, DIR_OFF, 32'h000FF},
      '{OUT_ON_OFF, 32'h0F0F0, OUT_ON_OFF, 32'h0F0F0},
      '{OUT_OFF_OFF, 32'h0F000, OUT_ON_OFF, 32'h000F0},
      '{EV_EN_SET_OFF, 32'h7000F, EV_EN_CLR_OFF, 32'h7000F},
      '{EV_EN_CLR_OFF, 32'h00003, EV_EN_CLR_OFF, 32'h7000C},
      '{WK_EN_SET_OFF, 32'h00100, EV_EN_CLR_OFF, 32'h7010C},
      '{EV_FALL_OFF, 32'h00F00, EV_RISE_OFF, 32'h7F0FF},
      '{WK_RISE_OFF, 32'h00300, EV_FALL_OFF, 32'h00C00},
      '{MUX_IDX_OFF, 32'h11, MUX_VAL_OFF, 32'h0},
      '{MUX_VAL_OFF, 32'hF, MUX_VAL_OFF, 32'h7},
      '{MUX_IDX_OFF, 32'h10, MUX_VAL_OFF, BAD_IDX_WORD},
      '{MUX_IDX_OFF, 32'h13, MUX_VAL_OFF, BAD_IDX_WORD},
      '{MUX_IDX_OFF, 32'h0F, MUX_VAL_OFF, 32'h0}
    };
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    s_axi_wstrb = 4'hF;
    ext_lvl = 19'h0005A;
    periph_pins = '0;
    other_port_event = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rc(DIR_OFF, 32'h0, "dir reset");
    rc(EV_EN_CLR_OFF, 32'h0, "enable reset");
    rc(EV_RISE_OFF, 32'h7FFFF, "rising reset");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rc(rows[i].ra, rows[i].ex, "row readback");
    end
    $display("test rows done");
    wr(8'h38, 32'h1);
    chk("bresp", last_rsp, RESP_SLVERR);
    rc(8'h38, 32'h0, "unmapped data");
    chk("rresp", last_rsp, RESP_SLVERR);
    // Lane pins made outputs before the byte write
    wr(DIR_OFF, 32'h0FF00);
    wr(LANE_SEL_OFF, 32'h1);
    wr(LANE_DATA_OFF, 32'hA5);
    periph_pins <= {19'h10000, 19'h10000, 19'h10000};
    repeat (4) @(posedge clk);
    chk("lane drive", general_pin_drive.level[15:8], 8'hA5);
    chk("drive enable", general_pin_drive.enable, 19'h1FF00);
    rc(INPUT_OFF, 32'h1A55A, "input word");
    wr(LANE_SEL_OFF, 32'h0);
    rc(LANE_DATA_OFF, 32'h5A, "lane read");
    $display("test lanes done");
    wr(EV_EN_CLR_OFF, 32'h7FFFF);
    wr(EV_RISE_OFF, 32'h7FFFF);
    rd(EV_STAT_OFF, scratch);
    // Pin 0 rises, pin 1 falls against a rising choice
    ext_lvl <= 19'h00059;
    repeat (5) @(posedge clk);
    chk("req disabled", sysctrl_event_req, 0);
    rc(EV_STAT_OFF, 32'h1, "polled status");
    rc(EV_STAT_OFF, 32'h0, "status cleared");
    wr(EV_EN_SET_OFF, 32'h10101);
    wr(EV_FALL_OFF, 32'h10100);
    wr(OUT_OFF_OFF, 32'h100);
    wr(OUT_ON_OFF, 32'h100);
    other_port_event <= 1'b1;
    @(posedge clk);
    other_port_event <= 1'b0;
    repeat (5) @(posedge clk);
    chk("req output pin", sysctrl_event_req, 0);
    rc(EV_STAT_OFF, 32'h80100, "output and other");
    ext_lvl <= 19'h00059 ^ 19'h1;
    @(posedge clk);
    ext_lvl <= 19'h00059;
    periph_pins.level[16] <= 1'b0;
    repeat (5) @(posedge clk);
    chk("req enabled", sysctrl_event_req, 1);
    rc(EV_STAT_OFF, 32'h10001, "owned pin status");
    repeat (2) @(posedge clk);
    chk("req cleared", sysctrl_event_req, 0);
    $display("test events done");
    // Second reset with pins high: settings return to reset, no false edge
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rc(EV_EN_CLR_OFF, 32'h0, "enable after reset");
    rc(EV_STAT_OFF, 32'h0, "status after reset");
    $display("test reset again done");
    conclude();
  end
endmodule // tb
